// file: rtl/psr_pkg.sv
// Package for the parallel-load shift register block.
// Assumes a single clock domain; all users import psr_pkg::*.
package psr_pkg;

  // ==========================================================
  // Sizes
  localparam int STAGES = 8;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // Values after reset or clear
  localparam logic [STAGES-1:0] STAGES_RESET = 8'h00;
  localparam logic NOR_PREV_RESET = 1'h1;

  // ==========================================================
  // Stage positions
  localparam int FIRST_STAGE = 0;
  localparam int LAST_STAGE = STAGES - 1;

  // Mode select levels
  localparam logic MODE_LOAD = 1'h0;
  localparam logic MODE_SHIFT = 1'h1;

endpackage

// file: rtl/psr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and one clock; ce freezes all state.
`timescale 1ns/100ps
`default_nettype none
module psr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } psr_fifo_state_type;

  psr_fifo_state_type s_q;
  psr_fifo_state_type s_d;

  // ==========================================================
  // Next state
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    s_d = s_q;
    push = in_valid && s_q.in_ready;
    // Output register refills whenever it is empty or being taken
    pop = (s_q.count != '0) && (!s_q.out_valid || out_ready);
    if (s_q.out_valid && out_ready) begin
      s_d.out_valid = 1'b0;
    end
    if (pop) begin
      s_d.out_data = s_q.mem[s_q.rd_ptr];
      s_d.out_valid = 1'b1;
      s_d.rd_ptr = PW'(s_q.rd_ptr + 1'b1);
    end
    if (push) begin
      s_d.mem[s_q.wr_ptr] = in_data;
      s_d.wr_ptr = PW'(s_q.wr_ptr + 1'b1);
    end
    if (push && !pop) begin
      s_d.count = CW'(s_q.count + 1'b1);
    end else if (pop && !push) begin
      s_d.count = CW'(s_q.count - 1'b1);
    end
    // Registered so the ready seen outside is honest for the next cycle
    s_d.in_ready = (s_d.count != CW'(DEPTH));
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.in_ready <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.in_ready;
  assign out_valid = s_q.out_valid;
  assign out_data = s_q.out_data;

endmodule
`default_nettype wire

// file: rtl/psr_shift_register.sv
// Eight-stage parallel-load / serial-in shift register, sampled design.
// Assumes all pins are synchronous to ref_clk; the pin clock pair is
// edge-detected at ref_clk rate, so it must be well below 100 MHz.
// Each pin-clock edge that shifts or loads also offers a snapshot of all stages to a small FIFO;
// a full FIFO drops it rather than stall the register.
// ce low freezes the stages, the edge history and the FIFO alike.
//
// How it works
// - With mode select high each active edge shifts the serial input into the register.
// - With mode select low the broadside inputs are copied in on the next active edge only.
// - During a broadside load the serial input is ignored by every stage.
// - The working clock is the NOR of the two clock pins and only its rising edge acts.
// - While either clock pin is high the other is ignored and all stages hold.
// - While either clock pin is low the other one serves as the clock, so a gate can stop it.
// - A low clear input zeroes all stages at the next ce-qualified ref_clk sample, overriding clocks, mode and data.
// - A serial bit reaches the last-stage output after exactly eight active edges.
// - A loaded last-stage bit appears on the last-stage output after one active edge.
`timescale 1ns/100ps
`default_nettype none
module psr_shift_register
  import psr_pkg::*;
#(
  parameter int WIDTH = STAGES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // Register pins
  input wire logic shift_mode,
  input wire logic serial_input,
  input wire logic [WIDTH-1:0] parallel_data,
  input wire logic clock_input,
  input wire logic clock_gate_input,
  input wire logic direct_clear_input_n,
  // Stage outputs
  output logic last_stage_output,
  output logic first_stage_value,
  // Snapshot stream after each shift or load edge
  output logic capture_ready,
  output logic snap_valid,
  output logic [WIDTH-1:0] snap_data,
  input wire logic snap_ready
);

  typedef struct packed {
    logic [WIDTH-1:0] stages;
    logic nor_prev;
    logic push;
    logic [WIDTH-1:0] push_data;
  } psr_state_type;

  psr_state_type s_q;
  psr_state_type s_d;
  logic fifo_in_ready;

  // ==========================================================
  // Stage actions
  // One action per ref_clk sample; clear outranks any pin-clock edge
  typedef enum logic [1:0] {
    ACT_HOLD = 2'b00,
    ACT_CLEAR = 2'b01,
    ACT_SHIFT = 2'b10,
    ACT_LOAD = 2'b11
  } psr_action_type;

  // ==========================================================
  // Helpers

  // Working clock of the stages: high only while both clock pins are low,
  // so either pin held high parks the other one
  function automatic logic clock_net(
    input logic clk_pin,
    input logic gate_pin
  );
    return ~(clk_pin | gate_pin);
  endfunction

  // Edge of the working clock between two ce-qualified samples; a slow
  // pin clock is needed, since a pulse shorter than one sample is lost
  function automatic logic rising(
    input logic now_level,
    input logic prev_level
  );
    return now_level & ~prev_level;
  endfunction

  // Clear first, then a pin-clock edge in the selected mode
  function automatic psr_action_type decode_action(
    input logic clear_n,
    input logic edge_seen,
    input logic mode
  );
    psr_action_type act;
    act = ACT_HOLD;
    if (!clear_n) begin
      act = ACT_CLEAR;
    end else if (edge_seen && (mode == MODE_SHIFT)) begin
      act = ACT_SHIFT;
    end else if (edge_seen) begin
      act = ACT_LOAD;
    end
    return act;
  endfunction

  // Serial bit enters the first stage; the last stage's bit drops off,
  // so eight edges carry a serial bit to the last-stage output
  function automatic logic [WIDTH-1:0] shift_in(
    input logic [WIDTH-1:0] cur,
    input logic serial_bit
  );
    return {cur[WIDTH-2:0], serial_bit};
  endfunction

  // A load takes the broadside word alone; the serial pin plays no part,
  // and the loaded last-stage bit shows at the output after one edge
  function automatic logic [WIDTH-1:0] load_in(
    input logic [WIDTH-1:0] par
  );
    return par;
  endfunction

  // Only a real pin-clock edge offers a snapshot,
  // so a clear never shows up in the snapshot stream
  function automatic logic takes_snapshot(
    input psr_action_type act
  );
    return (act == ACT_SHIFT) || (act == ACT_LOAD);
  endfunction

  // Next value of all stages for one action; hold is the default
  function automatic logic [WIDTH-1:0] next_stages(
    input psr_action_type act,
    input logic [WIDTH-1:0] cur,
    input logic serial_bit,
    input logic [WIDTH-1:0] par
  );
    logic [WIDTH-1:0] nxt;
    nxt = cur;
    case (act)
      ACT_CLEAR: begin
        nxt = WIDTH'(STAGES_RESET);
      end
      ACT_SHIFT: begin
        nxt = shift_in(cur, serial_bit);
      end
      ACT_LOAD: begin
        nxt = load_in(par);
      end
      default: begin
        nxt = cur;
      end
    endcase
    return nxt;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic nor_now;
    logic active_edge;
    psr_action_type action;
    nor_now = 1'b0;
    active_edge = 1'b0;
    action = ACT_HOLD;
    s_d = s_q;
    s_d.push = 1'b0;
    nor_now = clock_net(clock_input, clock_gate_input);
    active_edge = rising(nor_now, s_q.nor_prev);
    // History moves only with ce, so a frozen sample never fakes an edge
    s_d.nor_prev = nor_now;
    // Gate is taken to rise only while the clock pin is high
    action = decode_action(direct_clear_input_n, active_edge, shift_mode);
    s_d.stages = next_stages(action, s_q.stages, serial_input, parallel_data);
    // A full FIFO drops the snapshot; capture_ready low shows it, and
    // the stages never stall behind a slow consumer
    if (takes_snapshot(action)) begin
      s_d.push = 1'b1;
      s_d.push_data = s_d.stages;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.stages <= STAGES_RESET;
      // A NOR already high at release is history, not an edge
      s_q.nor_prev <= NOR_PREV_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Snapshot buffer
  // Snapshots are registered before the FIFO, so push and data agree
  psr_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(s_q.push),
    .in_data(s_q.push_data),
    .in_ready(fifo_in_ready),
    .out_valid(snap_valid),
    .out_data(snap_data),
    .out_ready(snap_ready)
  );

  // ==========================================================
  // Outputs, every one a flop: two stage taps and the FIFO's registers
  assign last_stage_output = s_q.stages[LAST_STAGE];
  assign first_stage_value = s_q.stages[FIRST_STAGE];
  assign capture_ready = fifo_in_ready;

endmodule
`default_nettype wire

// file: tb/psr_shift_register_properties.sv
// Pin-level checker for the shift register.
// Bound onto psr_shift_register; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module psr_checker
  import psr_pkg::*;
#(parameter int WIDTH = STAGES) (
  // Clocking
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // Pins
  input wire logic shift_mode,
  input wire logic serial_input,
  input wire logic [WIDTH-1:0] parallel_data,
  input wire logic clock_input,
  input wire logic clock_gate_input,
  input wire logic direct_clear_input_n,
  input wire logic last_stage_output,
  input wire logic first_stage_value
);
  logic nor_q;
  logic [WIDTH-1:0] sh_q;
  wire logic nor_w = ~(clock_input | clock_gate_input);
  wire logic act = ce & nor_w & ~nor_q & direct_clear_input_n;
  wire logic clr = ce & ~direct_clear_input_n;
  // ==========================================================
  // Shadow register; a NOR already high at release is no edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nor_q <= 1'h1;
      sh_q <= STAGES_RESET;
    end else if (ce) begin
      nor_q <= nor_w;
      if (clr) sh_q <= STAGES_RESET;
      else if (act) sh_q <= shift_mode ? {sh_q[WIDTH-2:0], serial_input} : parallel_data;
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence shift_s; act && shift_mode; endsequence
  sequence load_s; act && !shift_mode; endsequence
  shift_in_a: assert property (shift_s |=> first_stage_value == $past(serial_input))
    else $error("shift");
  load_first_a: assert property (load_s |=> first_stage_value == $past(parallel_data[0]))
    else $error("load first");
  load_last_a: assert property (load_s |=> last_stage_output == $past(parallel_data[WIDTH-1]))
    else $error("load last");
  edge_hold_a: assert property (ce && direct_clear_input_n && !act |=>
    $stable(last_stage_output) && $stable(first_stage_value)) else $error("no edge");
  gate_hold_a: assert property (clock_gate_input && direct_clear_input_n |=>
    $stable(last_stage_output)) else $error("gated");
  clear_zero_a: assert property (clr |=> !last_stage_output && !first_stage_value)
    else $error("clear");
  chain_last_a: assert property (last_stage_output == sh_q[WIDTH-1])
    else $error("last stage");
  chain_first_a: assert property (first_stage_value == sh_q[0])
    else $error("first stage");
  ce_hold_a: assert property (!ce |=>
    $stable(last_stage_output) && $stable(first_stage_value)) else $error("frozen");
endmodule
bind psr_shift_register psr_checker #(.WIDTH(WIDTH)) u_chk (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .ce(ce),
  .shift_mode(shift_mode),
  .serial_input(serial_input),
  .parallel_data(parallel_data),
  .clock_input(clock_input),
  .clock_gate_input(clock_gate_input),
  .direct_clear_input_n(direct_clear_input_n),
  .last_stage_output(last_stage_output),
  .first_stage_value(first_stage_value)
);
`default_nettype wire

// file: tb/psr_pin_driver.sv
// System logic: free-running pin clock and its gate.
// Runs from ref_clk; stop asks for the gate.
`timescale 1ns/100ps
`default_nettype none
module psr_pin_driver (
  // Clocking
  input wire logic ref_clk,
  input wire logic rstn,
  // Request
  input wire logic stop,
  // Pins
  output logic clock_input,
  output var logic clock_gate_input
);
  logic [1:0] cnt_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
      clock_gate_input <= 1'h1;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      // Gate moves mid-high phase only, so it never makes a stray edge
      if (cnt_q == 2'h2) clock_gate_input <= stop;
    end
  end
  assign clock_input = cnt_q[1];
endmodule
`default_nettype wire

// file: tb/parallel_load_shift_register8_tb_top.sv
// Bench for the shift register and its snapshot FIFO.
// Needs psr_pkg, the design, the checker and psr_pin_driver.
`timescale 1ns/100ps
`default_nettype none
module parallel_load_shift_register8_tb_top
  import psr_pkg::*;
;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic ce = 1'h1;
  logic stop = 1'h0;
  logic shift_mode = 1'h0;
  logic serial_input = 1'h0;
  logic [STAGES-1:0] parallel_data = 8'h00;
  logic direct_clear_input_n = 1'h1;
  logic snap_ready = 1'h1;
  logic clock_input, clock_gate_input, last_stage_output, first_stage_value;
  logic capture_ready, snap_valid;
  logic [STAGES-1:0] snap_data;
  int checks = 0;
  int miscompares = 0;
  always #2.5 ref_clk = ~ref_clk;
  psr_pin_driver u_pins (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .stop(stop),
    .clock_input(clock_input),
    .clock_gate_input(clock_gate_input)
  );
  psr_shift_register u_dut (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .shift_mode(shift_mode),
    .serial_input(serial_input),
    .parallel_data(parallel_data),
    .clock_input(clock_input),
    .clock_gate_input(clock_gate_input),
    .direct_clear_input_n(direct_clear_input_n),
    .last_stage_output(last_stage_output),
    .first_stage_value(first_stage_value),
    .capture_ready(capture_ready),
    .snap_valid(snap_valid),
    .snap_data(snap_data),
    .snap_ready(snap_ready)
  );
  // ==========================================================
  // Helpers
  task automatic step(input logic m, input logic s, input logic [7:0] p);
    @(posedge clock_input);
    shift_mode <= m;
    serial_input <= s;
    parallel_data <= p;
    @(negedge clock_input);
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic gate(input logic g);
    @(posedge ref_clk);
    stop <= g;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_load();
    step(MODE_LOAD, 1'h0, 8'h81);
    chk({last_stage_output, first_stage_value}, 8'h03);
    gate(1'h1);
    parallel_data <= 8'h80;
    repeat (8) @(posedge ref_clk);
    chk({last_stage_output, first_stage_value}, 8'h03);
    stop <= 1'h0;
    step(MODE_LOAD, 1'h0, 8'h80);
    chk({last_stage_output, first_stage_value}, 8'h02);
    $display("load and gate done");
  endtask
  task automatic t_shift();
    gate(1'h1);
    // With ce low even a clear must wait
    ce <= 1'h0;
    direct_clear_input_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({last_stage_output, first_stage_value}, 8'h02);
    @(posedge ref_clk);
    ce <= 1'h1;
    @(posedge ref_clk);
    direct_clear_input_n <= 1'h1;
    @(negedge ref_clk);
    chk({last_stage_output, first_stage_value}, 8'h00);
    stop <= 1'h0;
    for (int k = 1; k <= 8; k++) begin
      step(MODE_SHIFT, k == 1, 8'hff);
      chk({last_stage_output, first_stage_value}, {k == 8, k == 1});
    end
    $display("clear and shift done");
  endtask
  task automatic t_fifo();
    gate(1'h1);
    shift_mode <= MODE_LOAD;
    parallel_data <= 8'h10;
    snap_ready <= 1'h0;
    stop <= 1'h0;
    for (int k = 0; k < 10; k++) step(MODE_LOAD, 1'h0, 8'h10 + 8'(k));
    gate(1'h1);
    chk({snap_valid, capture_ready}, 8'h02);
    chk(snap_data, 8'h10);
    // One handshake per word; the tenth load found the FIFO full
    for (int k = 1; k <= 9; k++) begin
      @(posedge ref_clk);
      snap_ready <= 1'h1;
      @(posedge ref_clk);
      snap_ready <= 1'h0;
      @(negedge ref_clk);
      if (k < 9) begin
        chk(snap_data, 8'h10 + 8'(k));
      end
    end
    chk(snap_valid, 1'h0);
    $display("fifo done");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'h1;
    t_load();
    t_shift();
    t_fifo();
    complete_run();
  end
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
